// File: utx_pkg.sv
// Behaviour
// RULE1: bit 13 set makes the endpoint a transmit endpoint and clear makes it receive, which matters only for a shared FIFO; here it always gates dma_req.
// RULE2: the DMA request is raised only while the DMA-enable bit 12 is set.
// RULE3: with force-toggle bit 11 set, every finished attempt flips the toggle and drops the packet, acknowledged or not.
// RULE4: software always writes zero to the DMA request style bit 10.
// RULE5: a write with bit 9 set lets that same write load the toggle, and the enable is gone once the toggle is loaded.
// RULE6: bit 8 reads the current toggle, and a write to it counts only while the enable is high.
// RULE7: a bulk endpoint sets bit 7 and halts on NAK limit expiry, and software clears bit 7 to resume.
// RULE8: writing one to bit 6 resets the toggle to zero.
// RULE9: a STALL handshake sets bit 5, flushes the FIFO and disarms the packet, and software clears bit 5.
// RULE10: bit 4 written with the arm bit makes the transaction use a SETUP token instead of an OUT token.
// RULE11: setting the SETUP-select bit also clears the toggle.
// RULE12: writing one to bit 3 discards the next queued packet, resets the FIFO pointer and disarms the packet.
// RULE13: a flush is ignored unless the packet is armed, so a double-buffered FIFO may need two flushes.
// RULE14: in bulk or interrupt mode, 3 attempts without handshake set bit 2 and raise an interrupt, and software clears it.
// RULE15: bit 1 is high whenever at least one packet sits in the transmit FIFO.
// RULE16: software sets bit 0 after loading a packet, the block clears it once sent and raises an interrupt if enabled.
// RULE17: reserved bits 15 and 14 and the write-only action bits read zero, and every field resets to zero.
package utx_pkg;

   // register byte addresses
   localparam logic [7:0]  UTX_OFF_CSR       = 8'h00;
   localparam logic [7:0]  UTX_OFF_IRQ_STAT  = 8'h04;
   localparam logic [7:0]  UTX_OFF_IRQ_MASK  = 8'h08;

   // control/status field positions
   localparam int          UTX_B_DIR         = 13;
   localparam int          UTX_B_DMA_REQUEST_ENABLE       = 12;
   localparam int          UTX_B_FORCE       = 11;
   localparam int          UTX_B_STYLE       = 10;
   localparam int          UTX_B_TOGWREN     = 9;
   localparam int          UTX_B_TOGGLE      = 8;
   localparam int          UTX_B_NAKTO       = 7;
   localparam int          UTX_B_TOGCLR      = 6;
   localparam int          UTX_B_STALL       = 5;
   localparam int          UTX_B_SETUP       = 4;
   localparam int          UTX_B_FLUSH       = 3;
   localparam int          UTX_B_ERROR       = 2;
   localparam int          UTX_B_OCCUPIED    = 1;
   localparam int          UTX_B_ARMED       = 0;

   // interrupt status/mask field positions
   localparam int          UTX_I_SENT        = 0;
   localparam int          UTX_I_ERROR       = 1;
   localparam int          UTX_I_STALL       = 2;
   localparam int          UTX_I_NAKTO       = 3;
   localparam int          UTX_IRQ_W         = 4;

   // reset values
   localparam logic [15:0] UTX_CSR_RESET     = 16'h0000;
   localparam logic [3:0]  UTX_IRQ_RESET     = 4'h0;

   // counts
   localparam logic [1:0]  UTX_RETRY_LIMIT   = 2'h3;
   localparam logic [1:0]  UTX_PKT_DEPTH     = 2'h2;

   // endpoint transfer type, standard encoding
   localparam logic [1:0]  UTX_XFER_CTRL     = 2'h0;
   localparam logic [1:0]  UTX_XFER_ISO      = 2'h1;
   localparam logic [1:0]  UTX_XFER_BULK     = 2'h2;
   localparam logic [1:0]  UTX_XFER_INTR     = 2'h3;

   // bus responses
   localparam logic [1:0]  UTX_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  UTX_RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      UTX_RD_IDLE = 2'b01,
      UTX_RD_RESP = 2'b10
   } utx_rd_state_type;

endpackage

// File: utx_pkt_track.sv
`timescale 1ns/10ps
module utx_pkt_track
   import utx_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       pkt_load,
   input  wire logic       pkt_pop,
   input  wire logic       pkt_clear_all,
   input  wire logic       retry_enable,
   input  wire logic       no_handshake,
   input  wire logic       handshake_seen,
   output logic            queue_occupied,
   output logic            queue_full,
   output logic            retry_exhausted
);

   logic [1:0] pkt_count;
   logic [1:0] retry_count;

   // packet count of the double-buffered FIFO
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pkt_count <= 2'h0;
      end else if (pkt_clear_all) begin
         pkt_count <= 2'h0;
      end else if (pkt_load && !pkt_pop && pkt_count != UTX_PKT_DEPTH) begin
         pkt_count <= pkt_count + 2'h1;
      end else if (pkt_pop && !pkt_load && pkt_count != 2'h0) begin
         pkt_count <= pkt_count - 2'h1;
      end
   end

   // attempts without handshake; iso and control never count
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         retry_count     <= 2'h0;
         retry_exhausted <= 1'b0;
      end else begin
         retry_exhausted <= 1'b0;
         if (handshake_seen || pkt_clear_all || !retry_enable) begin
            retry_count <= 2'h0;
         end else if (no_handshake) begin
            if (retry_count + 2'h1 == UTX_RETRY_LIMIT) begin
               retry_count     <= 2'h0;
               retry_exhausted <= 1'b1; // [RULE14]
            end else begin
               retry_count <= retry_count + 2'h1;
            end
         end
      end
   end

   assign queue_occupied = (pkt_count != 2'h0); // [RULE15]
   assign queue_full     = (pkt_count == UTX_PKT_DEPTH);

endmodule

// File: utx_endpoint_csr.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module utx_endpoint_csr
   import utx_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // transaction engine, same clock
   input  wire logic [1:0]  xfer_type,
   input  wire logic        pkt_loaded,
   input  wire logic        attempt_done,
   input  wire logic        ack_received,
   input  wire logic        no_handshake,
   input  wire logic        stall_seen,
   input  wire logic        nak_limit_hit,
   output logic             tx_direction,
   output logic             dma_req,
   output logic             dma_request_style,
   output logic             tx_packet_armed,
   output logic             setup_token_select,
   output logic             data_toggle_state,
   output logic             endpoint_halted,
   output logic             discard_queued_packet,
   output logic             fifo_clear_all,
   output logic             queue_occupied,
   output logic             irq
);

   // byte enables widened to a bit mask for the low half-word
   function automatic logic [15:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      reg_hit = (addr[7:2] == offset[7:2]);
   endfunction

   // write channel
   logic             aw_full;
   logic             w_full;
   logic [7:0]       aw_addr;
   logic [31:0]      w_data;
   logic [3:0]       w_strb;
   logic             wr_fire;
   logic [15:0]      wmask;
   logic [15:0]      wset;
   logic [15:0]      wclr;
   logic             csr_wr;
   logic             stat_wr;
   logic             mask_wr;
   // read channel
   utx_rd_state_type rd_state;
   // fields
   logic             dir_tx;
   logic             dma_enable;
   logic             force_toggle_switch;
   logic             nak_timeout;
   logic             stall_received;
   logic             retry_error;
   logic [3:0]       irq_status;
   logic [3:0]       irq_mask;
   // engine events
   logic             send_done;
   logic             flush_req;
   logic             retry_exhausted;
   logic             queue_full;
   logic             retry_enable;
   logic             toggle_direct;
   logic [15:0]      csr_read;
   logic             pkt_pop;
   logic             nak_expired;

   // a held channel or a pending response refuses the next item
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign wr_fire       = aw_full && w_full && !s_axi_bvalid;
   assign wmask         = lane_mask(w_strb);
   assign wset          = w_data[15:0] & wmask;
   assign wclr          = ~w_data[15:0] & wmask;
   assign csr_wr        = wr_fire && reg_hit(aw_addr, UTX_OFF_CSR);
   assign stat_wr       = wr_fire && reg_hit(aw_addr, UTX_OFF_IRQ_STAT);
   assign mask_wr       = wr_fire && reg_hit(aw_addr, UTX_OFF_IRQ_MASK);

   // address and data are held separately so either may arrive first
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_full      <= 1'b0;
         w_full       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= UTX_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // an unmapped offset answers SLVERR and changes nothing
            s_axi_bresp  <= (csr_wr || stat_wr || mask_wr) ? UTX_RESP_OKAY : UTX_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read readback of the control/status view
   always_comb begin
      csr_read                 = UTX_CSR_RESET; // [RULE17]
      csr_read[UTX_B_DIR]      = dir_tx;
      csr_read[UTX_B_DMA_REQUEST_ENABLE]    = dma_enable;
      csr_read[UTX_B_FORCE]    = force_toggle_switch;
      csr_read[UTX_B_STYLE]    = dma_request_style;
      csr_read[UTX_B_TOGGLE]   = data_toggle_state; // [RULE6]
      csr_read[UTX_B_NAKTO]    = nak_timeout;
      csr_read[UTX_B_STALL]    = stall_received;
      csr_read[UTX_B_SETUP]    = setup_token_select;
      csr_read[UTX_B_ERROR]    = retry_error;
      csr_read[UTX_B_OCCUPIED] = queue_occupied;
      csr_read[UTX_B_ARMED]    = tx_packet_armed;
   end

   // arready drops while the answer stands, so one read is in flight
   assign s_axi_arready = (rd_state == UTX_RD_IDLE);
   assign s_axi_rvalid  = (rd_state == UTX_RD_RESP);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_state    <= UTX_RD_IDLE;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= UTX_RESP_OKAY;
      end else begin
         case (rd_state)
            UTX_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state    <= UTX_RD_RESP;
                  s_axi_rresp <= UTX_RESP_OKAY;
                  // the upper half-word of every register reads zero
                  if (reg_hit(s_axi_araddr, UTX_OFF_CSR)) begin
                     s_axi_rdata <= {16'h0000, csr_read};
                  end else if (reg_hit(s_axi_araddr, UTX_OFF_IRQ_STAT)) begin
                     s_axi_rdata <= {28'h000_0000, irq_status};
                  end else if (reg_hit(s_axi_araddr, UTX_OFF_IRQ_MASK)) begin
                     s_axi_rdata <= {28'h000_0000, irq_mask};
                  end else begin
                     s_axi_rdata <= 32'h0000_0000;
                     s_axi_rresp <= UTX_RESP_SLVERR;
                  end
               end
            end
            UTX_RD_RESP: begin
               // rdata and rresp stand until rready
               if (s_axi_rready) begin
                  rd_state <= UTX_RD_IDLE;
               end
            end
            default: begin
               rd_state <= UTX_RD_IDLE;
            end
         endcase
      end
   end

   // a forced toggle finishes on any attempt, otherwise only on an ACK
   assign send_done     = tx_packet_armed && (force_toggle_switch ? attempt_done : ack_received); // [RULE3]
   assign flush_req     = csr_wr && wset[UTX_B_FLUSH] && tx_packet_armed; // [RULE12] [RULE13]
   assign retry_enable  = (xfer_type == UTX_XFER_BULK) || (xfer_type == UTX_XFER_INTR);
   // enable and value travel in one write, so the enable never lingers
   assign toggle_direct = csr_wr && wset[UTX_B_TOGWREN] && wmask[UTX_B_TOGGLE]; // [RULE5]
   // a packet leaves the FIFO on a flush or a finished send
   assign pkt_pop       = flush_req || send_done;
   assign nak_expired   = nak_limit_hit && (xfer_type == UTX_XFER_BULK); // [RULE7]

   // plain configuration fields
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dir_tx              <= 1'b0;
         dma_enable          <= 1'b0;
         force_toggle_switch <= 1'b0;
         dma_request_style   <= 1'b0;
      end else if (csr_wr) begin
         // kept even for a dedicated FIFO, where it still gates dma_req
         if (wmask[UTX_B_DIR]) begin
            dir_tx <= w_data[UTX_B_DIR]; // [RULE1]
         end
         if (wmask[UTX_B_DMA_REQUEST_ENABLE]) begin
            dma_enable <= w_data[UTX_B_DMA_REQUEST_ENABLE];
         end
         if (wmask[UTX_B_FORCE]) begin
            force_toggle_switch <= w_data[UTX_B_FORCE];
         end
         // stored as written; software is expected to keep it zero
         if (wmask[UTX_B_STYLE]) begin
            dma_request_style <= w_data[UTX_B_STYLE]; // [RULE4]
         end
      end
   end

   // data toggle: software actions take priority over the hardware flip
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_toggle_state <= 1'b0;
      end else if (csr_wr && (wset[UTX_B_TOGCLR] || wset[UTX_B_SETUP])) begin
         data_toggle_state <= 1'b0; // [RULE8] [RULE11]
      end else if (toggle_direct) begin
         data_toggle_state <= w_data[UTX_B_TOGGLE]; // [RULE6]
      end else if (send_done) begin
         data_toggle_state <= ~data_toggle_state; // [RULE3]
      end
   end

   // setup token select, written together with the arm bit
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup_token_select <= 1'b0;
      end else if (csr_wr && wmask[UTX_B_SETUP]) begin
         setup_token_select <= w_data[UTX_B_SETUP]; // [RULE10]
      end
   end

   // packet armed: a software set in the same cycle wins over any clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_packet_armed <= 1'b0;
      end else if (csr_wr && wset[UTX_B_ARMED]) begin
         tx_packet_armed <= 1'b1; // [RULE16]
      end else if (send_done || stall_seen || flush_req) begin
         tx_packet_armed <= 1'b0; // [RULE9] [RULE12] [RULE16]
      end
   end

   // hardware-set flags cleared by writing zero; the set wins
   // writing one leaves a flag alone, so set bits survive a read-modify-write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         nak_timeout    <= 1'b0;
         stall_received <= 1'b0;
         retry_error    <= 1'b0;
      end else begin
         if (nak_expired) begin
            nak_timeout <= 1'b1; // [RULE7]
         end else if (csr_wr && wclr[UTX_B_NAKTO]) begin
            nak_timeout <= 1'b0;
         end
         if (stall_seen) begin
            stall_received <= 1'b1; // [RULE9]
         end else if (csr_wr && wclr[UTX_B_STALL]) begin
            stall_received <= 1'b0;
         end
         if (retry_exhausted) begin
            retry_error <= 1'b1; // [RULE14]
         end else if (csr_wr && wclr[UTX_B_ERROR]) begin
            retry_error <= 1'b0;
         end
      end
   end

   // one-cycle pulses towards the FIFO
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         discard_queued_packet <= 1'b0;
         fifo_clear_all        <= 1'b0;
      end else begin
         // registered to give the FIFO a clean one-cycle strobe
         discard_queued_packet <= pkt_pop; // [RULE12]
         fifo_clear_all        <= stall_seen; // [RULE9]
      end
   end

   // a stall empties both buffers and restarts the retry count
   utx_pkt_track u_track (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .pkt_load        (pkt_loaded),
      .pkt_pop         (pkt_pop),
      .pkt_clear_all   (stall_seen),
      .retry_enable    (retry_enable),
      .no_handshake    (no_handshake && tx_packet_armed),
      .handshake_seen  (ack_received || stall_seen || nak_limit_hit),
      .queue_occupied  (queue_occupied),
      .queue_full      (queue_full),
      .retry_exhausted (retry_exhausted)
   );

   // interrupt status: write one to clear, a new event wins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status <= UTX_IRQ_RESET;
      end else begin
         irq_status[UTX_I_SENT]  <= send_done ||
                                    (irq_status[UTX_I_SENT] && !(stat_wr && wset[UTX_I_SENT])); // [RULE16]
         irq_status[UTX_I_ERROR] <= retry_exhausted ||
                                    (irq_status[UTX_I_ERROR] && !(stat_wr && wset[UTX_I_ERROR])); // [RULE14]
         irq_status[UTX_I_STALL] <= stall_seen ||
                                    (irq_status[UTX_I_STALL] && !(stat_wr && wset[UTX_I_STALL]));
         irq_status[UTX_I_NAKTO] <= nak_expired ||
                                    (irq_status[UTX_I_NAKTO] && !(stat_wr && wset[UTX_I_NAKTO]));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask <= UTX_IRQ_RESET;
      end else if (mask_wr && wmask[0]) begin
         irq_mask <= w_data[UTX_IRQ_W-1:0];
      end
   end

   // level output, so a mask write takes effect at once
   assign irq             = |(irq_status & irq_mask);
   assign tx_direction    = dir_tx;
   assign endpoint_halted = nak_timeout; // [RULE7]
   // no request once both buffers hold a packet, to avoid overfilling
   assign dma_req         = dma_enable && dir_tx && !queue_full; // [RULE2]

endmodule

// File: utx_endpoint_csr_sva.sv
`timescale 1ns/10ps
module utx_endpoint_csr_sva
   import utx_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [1:0] xfer_type,
   input wire logic       pkt_loaded,
   input wire logic       ack_received,
   input wire logic       stall_seen,
   input wire logic       nak_limit_hit,
   input wire logic       tx_direction,
   input wire logic       dma_req,
   input wire logic       tx_packet_armed,
   input wire logic       data_toggle_state,
   input wire logic       endpoint_halted,
   input wire logic       discard_queued_packet,
   input wire logic       fifo_clear_all,
   input wire logic       queue_occupied,
   input wire logic       irq,
   input wire logic       s_axi_bvalid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   dma_gate_a: assert property (dma_req |-> tx_direction)
      else $error("dma request while not transmit");
   send_done_a: assert property (tx_packet_armed && ack_received && !stall_seen |=>
      !tx_packet_armed && discard_queued_packet && data_toggle_state != $past(data_toggle_state))
      else $error("send completion not handled");
   stall_flush_a: assert property (stall_seen && !pkt_loaded |=> fifo_clear_all && !queue_occupied)
      else $error("stall did not flush");
   nak_halt_a: assert property (nak_limit_hit && xfer_type == UTX_XFER_BULK |=> endpoint_halted)
      else $error("bulk nak limit did not halt");
   nak_other_a: assert property (nak_limit_hit && xfer_type != UTX_XFER_BULK && !endpoint_halted
      |=> !endpoint_halted)
      else $error("non-bulk nak limit halted");
   occ_set_a: assert property (pkt_loaded && !stall_seen |=> queue_occupied)
      else $error("loaded packet not shown");
   occ_hold_a: assert property (queue_occupied && !stall_seen |=> queue_occupied || discard_queued_packet)
      else $error("occupied flag dropped without removal");
   reset_zero_a: assert property (disable iff (1'b0) rst |=>
      !irq && !tx_packet_armed && !queue_occupied && !data_toggle_state && !s_axi_bvalid)
      else $error("state not cleared by reset");
endmodule

bind utx_endpoint_csr utx_endpoint_csr_sva utx_endpoint_csr_sva_inst (.*);

// File: utx_peer.sv
`timescale 1ns/10ps
module utx_peer
   import utx_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [1:0] reply,
   input  wire logic [3:0] dly,
   output logic            attempt_done,
   output logic            ack_received,
   output logic            no_handshake,
   output logic            stall_seen,
   output logic            nak_limit_hit
);
   // reply 0 ack, 1 silent, 2 stall, 3 nak until limit; dly sets prompt or slow answers
   logic [4:0] cnt;
   always_ff @(posedge sys_clk) begin
      attempt_done  <= 1'h0;
      ack_received  <= 1'h0;
      no_handshake  <= 1'h0;
      stall_seen    <= 1'h0;
      nak_limit_hit <= 1'h0;
      if (rst) begin
         cnt <= 5'h00;
      end else if (go) begin
         cnt <= {1'h0, dly} + 5'h01;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
         if (cnt == 5'h01) begin
            // a silent peer still ends the attempt through the host's own timeout
            attempt_done  <= (reply != 2'h3);
            ack_received  <= (reply == 2'h0);
            no_handshake  <= (reply == 2'h1);
            stall_seen    <= (reply == 2'h2);
            nak_limit_hit <= (reply == 2'h3);
         end
      end
   end
endmodule

// File: utx_endpoint_csr_tb.sv
`timescale 1ns/10ps
module utx_endpoint_csr_tb
   import utx_pkg::*;
;
   logic        sys_clk = 1'h0, rst = 1'h1, go = 1'h0, pkt_loaded = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF, dly = 4'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, xfer_type = 2'h0, reply = 2'h0;
   logic        attempt_done, ack_received, no_handshake, stall_seen, nak_limit_hit;
   logic        tx_direction, dma_req, dma_request_style, tx_packet_armed, setup_token_select;
   logic        data_toggle_state, endpoint_halted, discard_queued_packet, fifo_clear_all;
   logic        queue_occupied, irq;
   int          fails = 0, check_count = 0;

   utx_endpoint_csr utx_endpoint_csr_inst (.*);
   utx_peer         utx_peer_inst (.*);

   always #5 sys_clk = ~sys_clk;

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, da, dw;
      logic [1:0] r;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      da = 1'h0;
      dw = 1'h0;
      while (!(da && dw)) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         da = da || ta;
         dw = dw || tw;
      end
      do @(negedge sys_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'h0;
      chk(32'(r), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] v;
      logic [1:0]  r;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do @(negedge sys_clk); while (!s_axi_arready);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'h0;
      do @(negedge sys_clk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'h0;
      chk(v, e);
      chk(32'(r), 32'(er));
   endtask

   task automatic wc(input logic [15:0] d);
      wr(UTX_OFF_CSR, {16'h0000, d}, UTX_RESP_OKAY);
   endtask

   task automatic rc(input logic [15:0] e);
      rd(UTX_OFF_CSR, {16'h0000, e}, UTX_RESP_OKAY);
   endtask

   task automatic pl;
      @(posedge sys_clk);
      pkt_loaded <= 1'h1;
      @(posedge sys_clk);
      pkt_loaded <= 1'h0;
   endtask

   task automatic peer(input logic [1:0] r, input logic [3:0] d);
      @(posedge sys_clk);
      reply <= r;
      dly   <= d;
      go    <= 1'h1;
      @(posedge sys_clk);
      go <= 1'h0;
      repeat (int'(d) + 4) @(posedge sys_clk);
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'h0;
      rc(16'h0000);
      rd(UTX_OFF_IRQ_STAT, 32'h0, UTX_RESP_OKAY);
      rd(UTX_OFF_IRQ_MASK, 32'h0, UTX_RESP_OKAY);
      rd(8'h0C, 32'h0, UTX_RESP_SLVERR);
      wr(8'h0C, 32'h3000, UTX_RESP_SLVERR);
      wc(16'h3000);
      rc(16'h3000);
      chk(32'(tx_direction), 32'h1);
      chk(32'(dma_req), 32'h1);
      chk(32'(dma_request_style), 32'h0);
      wc(16'h2000);
      chk(32'(dma_req), 32'h0);
      // toggle load only under its enable; action bits read back zero
      wc(16'h2100);
      rc(16'h2000);
      wc(16'h2300);
      rc(16'h2100);
      chk(32'(data_toggle_state), 32'h1);
      wc(16'hE248);
      rc(16'h2000);
      // packet sent with a slow ack
      wr(UTX_OFF_IRQ_MASK, 32'hF, UTX_RESP_OKAY);
      pl();
      rc(16'h2002);
      wc(16'h2301);
      rc(16'h2103);
      peer(2'h0, 4'h9);
      rc(16'h2000);
      chk(32'(irq), 32'h1);
      rd(UTX_OFF_IRQ_STAT, 32'h1, UTX_RESP_OKAY);
      wr(UTX_OFF_IRQ_STAT, 32'h1, UTX_RESP_OKAY);
      chk(32'(irq), 32'h0);
      // flush refused while disarmed, setup token, double-buffer flush
      pl();
      wc(16'h2008);
      rc(16'h2002);
      wc(16'h2300);
      wc(16'h2011);
      rc(16'h2013);
      chk(32'(setup_token_select), 32'h1);
      pl();
      wc(16'h2008);
      rc(16'h2002);
      wc(16'h2001);
      wc(16'h2008);
      rc(16'h2000);
      // forced toggle on an isochronous attempt with no handshake
      xfer_type <= UTX_XFER_ISO;
      pl();
      wc(16'h2801);
      peer(2'h1, 4'h0);
      rc(16'h2900);
      // retry exhaustion counted on the third silent attempt
      xfer_type <= UTX_XFER_INTR;
      pl();
      wc(16'h2001);
      peer(2'h1, 4'h0);
      peer(2'h1, 4'h2);
      rc(16'h2103);
      peer(2'h1, 4'h0);
      rc(16'h2107);
      wc(16'h2101);
      rc(16'h2103);
      peer(2'h2, 4'h1);
      rc(16'h2120);
      wc(16'h2100);
      rc(16'h2100);
      xfer_type <= UTX_XFER_BULK;
      peer(2'h3, 4'h0);
      rc(16'h2180);
      chk(32'(endpoint_halted), 32'h1);
      wc(16'h2100);
      chk(32'(endpoint_halted), 32'h0);
      xfer_type <= UTX_XFER_INTR;
      peer(2'h3, 4'h0);
      rc(16'h2100);
      // interrupt status, mask and write-one clear
      rd(UTX_OFF_IRQ_STAT, 32'hF, UTX_RESP_OKAY);
      chk(32'(irq), 32'h1);
      wr(UTX_OFF_IRQ_MASK, 32'h0, UTX_RESP_OKAY);
      chk(32'(irq), 32'h0);
      wr(UTX_OFF_IRQ_STAT, 32'h5, UTX_RESP_OKAY);
      rd(UTX_OFF_IRQ_STAT, 32'hA, UTX_RESP_OKAY);
      close_out();
   end
endmodule
